//--- rtl/stecr_pkg.sv
// stecr_pkg: constants for the sensor timing and event configuration registers.
// assumes a 20 MHz core clock; every count derives from the printed times.
package stecr_pkg;
    // core clock
    localparam int CLK_PERIOD_NS = 50;
    // time units as printed, and their cycle counts
    localparam int ULP_UNIT_MS = 16;
    localparam int ULP_UNIT_CYCLES = ULP_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int AUTO_UNIT_MS = 500;
    localparam int AUTO_UNIT_CYCLES = AUTO_UNIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RDY_UNIT_US = 320;
    localparam int RDY_UNIT_CYCLES = RDY_UNIT_US * 1000 / CLK_PERIOD_NS;
    localparam int PWM_FREQ_HZ = 1000;
    localparam int PWM_PERIOD_CYCLES = 1000000000 / PWM_FREQ_HZ / CLK_PERIOD_NS;
    localparam int PWM_STEP_BITS = 8;
    // register offsets
    localparam logic [7:0] ADDR_POWER_MODE = 8'hd2;
    localparam logic [7:0] ADDR_ULP_PERIOD = 8'hd5;
    localparam logic [7:0] ADDR_AUTO_TIMER = 8'hd6;
    localparam logic [7:0] ADDR_EVENT_MASK = 8'hd7;
    localparam logic [7:0] ADDR_PULSE_DUTY = 8'hd8;
    localparam logic [7:0] ADDR_READY_TIMEOUT = 8'hd9;
    localparam logic [7:0] ADDR_SERIAL_BUS = 8'hda;
    localparam logic [7:0] ADDR_RESEED_GATE = 8'hdb;
    // reset values
    localparam logic [7:0] RST_POWER_MODE = 8'h03;
    localparam logic [7:0] RST_ULP_PERIOD = 8'h08;
    localparam logic [7:0] RST_AUTO_TIMER = 8'h14;
    localparam logic [7:0] RST_EVENT_MASK = 8'h00;
    localparam logic [7:0] RST_PULSE_DUTY = 8'h00;
    localparam logic [7:0] RST_READY_TIMEOUT = 8'h20;
    localparam logic [7:0] RST_SERIAL_BUS = 8'h01;
    localparam logic [7:0] RST_RESEED_GATE = 8'h07;
    // writable bits of the mixed registers
    localparam logic [7:0] SERIAL_BUS_WMASK = 8'h81;
    localparam logic [7:0] RESEED_GATE_WMASK = 8'h07;
    // field positions
    localparam int PULSE_ENABLE_BIT = 7;
    localparam int STOP_IGNORE_BIT = 7;
    localparam int RESEED_CHANNELS = 3;
    localparam int EVENT_SOURCES = 8;
    // event mask bit positions
    localparam int ABSORPTION_ACTIVE_BIT = 7;
    localparam int POWER_UNIT_EVENT_BIT = 6;
    localparam int SYSTEM_EVENT_BIT = 5;
    localparam int TEMPERATURE_EVENT_BIT = 4;
    localparam int HYSTERESIS_EVENT_BIT = 3;
    localparam int HALL_EVENT_BIT = 2;
    localparam int ABSORPTION_EVENT_BIT = 1;
    localparam int PROXIMITY_EVENT_BIT = 0;
    // communication window states
    typedef enum logic [2:0] {
        WIN_CLOSED = 3'b001,
        WIN_OPEN = 3'b010,
        WIN_LINGER = 3'b100
    } stecr_win_t;
endpackage : stecr_pkg

//--- rtl/stecr_regs.sv
// stecr_regs: timing, event mask, pulse output, window and reseed configuration.
// assumes a serial-bus engine on linkClk hands over decoded starts, stops and
// register accesses; sensing logic on ref_clk supplies events and reseed requests.
// Functional notes
// - low-power report period is register value times 16 ms, reset 8
// - auto mode switch time is register value times 500 ms, reset 20
// - mask bits 7..4 suppress activation, power unit, system, temperature events
// - mask bits 3..0 gate hysteresis, hall, absorption, proximity; reset all allowed
// - 1 kHz pulse output, high fraction (duty+1)/256
// - pulse output reaches the pin only while power mode bit 7 is set
// - ready-line timeout is register value times 0.32 ms, reset 32
// - with stop-ignore clear, a stop closes the communication window
// - with stop-ignore set, window closes only if no start within the timeout
// - reseed gate bits 2..0 enable auto reseed per channel, reset enabled
// - gate affects only halt timeout reseeds, other reseeds pass untouched
// - reseed-all command reseeds every channel regardless of the gate
// - pulse output enabled disables the inductive transmit function
`timescale 1ns/100ps
`default_nettype none
module stecr_regs #(
    parameter int ULP_UNIT_CYCLES = stecr_pkg::ULP_UNIT_CYCLES,
    parameter int AUTO_UNIT_CYCLES = stecr_pkg::AUTO_UNIT_CYCLES,
    parameter int RDY_UNIT_CYCLES = stecr_pkg::RDY_UNIT_CYCLES,
    parameter int PWM_PERIOD_CYCLES = stecr_pkg::PWM_PERIOD_CYCLES
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic linkClk,
    input wire logic linkStart,
    input wire logic linkStop,
    input wire logic linkWrEn,
    input wire logic linkRdEn,
    input wire logic [7:0] linkAddr,
    input wire logic [7:0] linkWrData,
    output logic [7:0] linkRdData,
    output logic linkBusy,
    input wire logic [7:0] eventRaw,
    output logic [7:0] eventOut,
    input wire logic modeActivity,
    output logic ulpReportTick,
    output logic autoSwitchReq,
    input wire logic [2:0] haltReseed,
    input wire logic [2:0] otherReseed,
    input wire logic reseedAllCmd,
    output logic [2:0] reseedChannel,
    output logic pulseOutputPin,
    output logic inductiveTxEnable,
    output logic commWindowOpen
);
    localparam int UW = $clog2(ULP_UNIT_CYCLES);
    localparam int AW = $clog2(AUTO_UNIT_CYCLES);
    localparam int RW = $clog2(RDY_UNIT_CYCLES);
    localparam int PW = $clog2(PWM_PERIOD_CYCLES);

    // counters need at least two cycles per unit
    if (ULP_UNIT_CYCLES < 2 || AUTO_UNIT_CYCLES < 2 || RDY_UNIT_CYCLES < 2 || PWM_PERIOD_CYCLES < 2) begin : gBadUnit
        $error("stecr_regs: unit cycle counts must be at least 2");
    end

    // ---------------- link domain ----------------
    logic startTog;
    logic stopTog;
    logic reqTog;
    logic reqWrite;
    logic [7:0] reqAddr;
    logic [7:0] reqData;
    logic ackTog;
    logic ackSync;
    logic [7:0] rdHold;

    // starts and stops leave the link domain as toggles
    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            startTog <= 1'b0;
            stopTog <= 1'b0;
        end else begin
            if (linkStart) begin
                startTog <= ~startTog;
            end
            if (linkStop) begin
                stopTog <= ~stopTog;
            end
        end
    end

    // one access in flight; address and data stay still until acknowledged
    always_ff @(posedge linkClk or negedge arst_n) begin
        if (!arst_n) begin
            reqTog <= 1'b0;
            reqWrite <= 1'b0;
            reqAddr <= 8'h00;
            reqData <= 8'h00;
            linkBusy <= 1'b0;
            linkRdData <= 8'h00;
        end else if ((linkWrEn || linkRdEn) && !linkBusy) begin
            reqTog <= ~reqTog;
            reqWrite <= linkWrEn;
            reqAddr <= linkAddr;
            reqData <= linkWrData;
            linkBusy <= 1'b1;
        end else if (linkBusy && (ackSync == reqTog)) begin
            linkBusy <= 1'b0;
            linkRdData <= rdHold; // stable since the edge that toggled the ack
        end
    end

    stecr_sync uAckSync (.clk(linkClk), .arst_n(arst_n), .din(ackTog), .dout(ackSync));

    // ---------------- core domain ----------------
    logic startSync;
    logic stopSync;
    logic reqSync;
    logic startPrev;
    logic stopPrev;
    logic reqPrev;
    logic startEvt;
    logic stopEvt;
    logic reqEvt;

    stecr_sync uStartSync (.clk(ref_clk), .arst_n(arst_n), .din(startTog), .dout(startSync));
    stecr_sync uStopSync (.clk(ref_clk), .arst_n(arst_n), .din(stopTog), .dout(stopSync));
    stecr_sync uReqSync (.clk(ref_clk), .arst_n(arst_n), .din(reqTog), .dout(reqSync));

    // edge memory for the synchronised toggles
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            startPrev <= 1'b0;
            stopPrev <= 1'b0;
            reqPrev <= 1'b0;
        end else begin
            startPrev <= startSync;
            stopPrev <= stopSync;
            reqPrev <= reqSync;
        end
    end

    assign startEvt = startSync ^ startPrev;
    assign stopEvt = stopSync ^ stopPrev;
    assign reqEvt = reqSync ^ reqPrev;

    // register file
    logic [7:0] powerMode;
    logic [7:0] ulpReportPeriod;
    logic [7:0] autoModeTimer;
    logic [7:0] eventMask;
    logic [7:0] pulseDuty;
    logic [7:0] readyTimeout;
    logic [7:0] serialBus;
    logic [2:0] reseedGate;
    logic [7:0] readMux;

    // readback; unmapped offsets and reserved bits read zero
    always_comb begin
        unique case (reqAddr)
            stecr_pkg::ADDR_POWER_MODE: readMux = powerMode;
            stecr_pkg::ADDR_ULP_PERIOD: readMux = ulpReportPeriod;
            stecr_pkg::ADDR_AUTO_TIMER: readMux = autoModeTimer;
            stecr_pkg::ADDR_EVENT_MASK: readMux = eventMask;
            stecr_pkg::ADDR_PULSE_DUTY: readMux = pulseDuty;
            stecr_pkg::ADDR_READY_TIMEOUT: readMux = readyTimeout;
            stecr_pkg::ADDR_SERIAL_BUS: readMux = serialBus;
            stecr_pkg::ADDR_RESEED_GATE: readMux = {5'h00, reseedGate};
            default: readMux = 8'h00;
        endcase
    end

    // writes land one cycle after the request toggle is seen
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            powerMode <= stecr_pkg::RST_POWER_MODE;
            ulpReportPeriod <= stecr_pkg::RST_ULP_PERIOD;
            autoModeTimer <= stecr_pkg::RST_AUTO_TIMER;
            eventMask <= stecr_pkg::RST_EVENT_MASK;
            pulseDuty <= stecr_pkg::RST_PULSE_DUTY;
            readyTimeout <= stecr_pkg::RST_READY_TIMEOUT;
            serialBus <= stecr_pkg::RST_SERIAL_BUS;
            reseedGate <= stecr_pkg::RST_RESEED_GATE[2:0];
        end else if (reqEvt && reqWrite) begin
            unique case (reqAddr)
                stecr_pkg::ADDR_POWER_MODE: powerMode <= reqData;
                stecr_pkg::ADDR_ULP_PERIOD: ulpReportPeriod <= reqData;
                stecr_pkg::ADDR_AUTO_TIMER: autoModeTimer <= reqData;
                stecr_pkg::ADDR_EVENT_MASK: eventMask <= reqData;
                stecr_pkg::ADDR_PULSE_DUTY: pulseDuty <= reqData;
                stecr_pkg::ADDR_READY_TIMEOUT: readyTimeout <= reqData;
                stecr_pkg::ADDR_SERIAL_BUS: serialBus <= reqData & stecr_pkg::SERIAL_BUS_WMASK;
                stecr_pkg::ADDR_RESEED_GATE: reseedGate <= reqData[2:0];
                default: ;
            endcase
        end
    end

    // answer every access; the ack toggle changes on the same edge as the held read data
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdHold <= 8'h00;
            ackTog <= 1'b0;
        end else if (reqEvt) begin
            rdHold <= readMux;
            ackTog <= reqSync;
        end
    end

    // event gating: a set mask bit suppresses its source
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            eventOut <= 8'h00;
        end else begin
            eventOut <= eventRaw & ~eventMask;
        end
    end

    // low-power report period; zero stops the report
    logic [UW-1:0] ulpCount;
    logic [7:0] ulpUnits;
    logic ulpWrap;
    assign ulpWrap = (ulpCount == UW'(ULP_UNIT_CYCLES - 1));
    // a new period restarts the unit count so a shorter value never overshoots
    logic ulpRestart;
    assign ulpRestart = reqEvt && reqWrite && (reqAddr == stecr_pkg::ADDR_ULP_PERIOD);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ulpCount <= '0;
            ulpUnits <= 8'h00;
            ulpReportTick <= 1'b0;
        end else begin
            ulpReportTick <= 1'b0;
            if (ulpReportPeriod == 8'h00 || ulpRestart) begin
                ulpCount <= '0;
                ulpUnits <= 8'h00;
            end else if (ulpWrap) begin
                ulpCount <= '0;
                if (ulpUnits >= ulpReportPeriod - 8'h01) begin
                    ulpUnits <= 8'h00;
                    ulpReportTick <= 1'b1;
                end else begin
                    ulpUnits <= ulpUnits + 8'h01;
                end
            end else begin
                ulpCount <= ulpCount + 1'b1;
            end
        end
    end

    // auto mode switch: fires once per quiet spell, activity restarts it
    logic [AW-1:0] autoCount;
    logic [7:0] autoUnits;
    logic autoArmed;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            autoCount <= '0;
            autoUnits <= 8'h00;
            autoArmed <= 1'b1;
            autoSwitchReq <= 1'b0;
        end else begin
            autoSwitchReq <= 1'b0;
            if (modeActivity || autoModeTimer == 8'h00) begin
                autoCount <= '0;
                autoUnits <= 8'h00;
                autoArmed <= 1'b1;
            end else if (autoArmed) begin
                if (autoCount == AW'(AUTO_UNIT_CYCLES - 1)) begin
                    autoCount <= '0;
                    if (autoUnits >= autoModeTimer - 8'h01) begin
                        autoArmed <= 1'b0;
                        autoSwitchReq <= 1'b1;
                    end else begin
                        autoUnits <= autoUnits + 8'h01;
                    end
                end else begin
                    autoCount <= autoCount + 1'b1;
                end
            end
        end
    end

    // pulse output: threshold is (duty+1)/256 of the 1 kHz period
    logic [PW-1:0] pwmPhase;
    logic [31:0] pwmProduct;
    logic [PW:0] pwmThreshold; // one bit wider: full duty equals the whole period
    logic pulseEnable;
    assign pulseEnable = powerMode[stecr_pkg::PULSE_ENABLE_BIT];
    assign pwmProduct = (32'(pulseDuty) + 32'h1) * 32'(PWM_PERIOD_CYCLES);
    assign pwmThreshold = (PW + 1)'(pwmProduct >> stecr_pkg::PWM_STEP_BITS);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwmPhase <= '0;
        end else if (pwmPhase == PW'(PWM_PERIOD_CYCLES - 1)) begin
            pwmPhase <= '0;
        end else begin
            pwmPhase <= pwmPhase + 1'b1;
        end
    end

    // the shared pin belongs to either the pulse or the inductive transmitter
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pulseOutputPin <= 1'b0;
            inductiveTxEnable <= 1'b1;
        end else begin
            pulseOutputPin <= pulseEnable && ({1'b0, pwmPhase} < pwmThreshold);
            inductiveTxEnable <= !pulseEnable;
        end
    end

    // communication window; a lingering window waits for a new start
    stecr_pkg::stecr_win_t winState;
    stecr_pkg::stecr_win_t next_winState;
    logic [RW-1:0] rdyCount;
    logic [7:0] rdyUnits;
    logic rdyExpired;
    logic stopIgnore;
    assign stopIgnore = serialBus[stecr_pkg::STOP_IGNORE_BIT];
    assign rdyExpired = (readyTimeout == 8'h00) ||
                        ((rdyCount == RW'(RDY_UNIT_CYCLES - 1)) && (rdyUnits >= readyTimeout - 8'h01));

    always_comb begin
        next_winState = winState;
        unique case (winState)
            stecr_pkg::WIN_CLOSED: if (startEvt) next_winState = stecr_pkg::WIN_OPEN;
            stecr_pkg::WIN_OPEN: begin
                if (stopEvt && !startEvt) begin
                    next_winState = stopIgnore ? stecr_pkg::WIN_LINGER : stecr_pkg::WIN_CLOSED;
                end
            end
            stecr_pkg::WIN_LINGER: begin
                if (startEvt) begin
                    next_winState = stecr_pkg::WIN_OPEN;
                end else if (rdyExpired) begin
                    next_winState = stecr_pkg::WIN_CLOSED;
                end
            end
            default: next_winState = stecr_pkg::WIN_CLOSED;
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            winState <= stecr_pkg::WIN_CLOSED;
            commWindowOpen <= 1'b0;
        end else begin
            winState <= next_winState;
            commWindowOpen <= (next_winState != stecr_pkg::WIN_CLOSED);
        end
    end

    // timeout counter runs only while lingering
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdyCount <= '0;
            rdyUnits <= 8'h00;
        end else if (winState != stecr_pkg::WIN_LINGER) begin
            rdyCount <= '0;
            rdyUnits <= 8'h00;
        end else if (rdyCount == RW'(RDY_UNIT_CYCLES - 1)) begin
            rdyCount <= '0;
            rdyUnits <= rdyUnits + 8'h01;
        end else begin
            rdyCount <= rdyCount + 1'b1;
        end
    end

    // reseed: gate applies to halt timeouts only, reseed-all overrides
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            reseedChannel <= 3'h0;
        end else begin
            reseedChannel <= (haltReseed & reseedGate) | otherReseed | {3{reseedAllCmd}};
        end
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence stopInOpen;
        winState == stecr_pkg::WIN_OPEN && stopEvt && !startEvt;
    endsequence

    event_mask_a: assert property (##1 eventOut == ($past(eventRaw) & ~$past(eventMask)))
        else $error("masked event leaked or allowed event lost");
    mask_reset_a: assert property ($rose(arst_n) |-> eventMask == 8'h00)
        else $error("event mask not cleared at reset");
    ulp_tick_a: assert property (ulpReportTick |-> $past(ulpUnits) == $past(ulpReportPeriod) - 8'h01)
        else $error("report tick at wrong unit count");
    auto_switch_a: assert property (autoSwitchReq && !modeActivity && autoModeTimer != 8'h00
                                    |=> !autoSwitchReq && !autoArmed)
        else $error("auto switch fired twice");
    pulse_gate_a: assert property (!pulseEnable ##1 !pulseEnable |-> !pulseOutputPin)
        else $error("pulse on pin while disabled");
    pulse_full_a: assert property (pulseEnable && pulseDuty == 8'hff |=> pulseOutputPin)
        else $error("full duty pulse went low");
    tx_off_a: assert property (pulseEnable |=> !inductiveTxEnable)
        else $error("inductive transmit left on with pulse output");
    stop_close_a: assert property (stopInOpen and !stopIgnore |=> !commWindowOpen)
        else $error("stop did not close window");
    stop_linger_a: assert property (stopInOpen and stopIgnore |=> commWindowOpen && winState == stecr_pkg::WIN_LINGER)
        else $error("ignored stop closed window");
    reseed_all_a: assert property (reseedAllCmd |=> reseedChannel == 3'h7)
        else $error("reseed-all missed a channel");
    reseed_gate_a: assert property (haltReseed[0] && !reseedGate[0] && !otherReseed[0] && !reseedAllCmd
                                    |=> !reseedChannel[0])
        else $error("gated halt reseed passed");
endmodule : stecr_regs
`default_nettype wire

//--- rtl/stecr_sync.sv
// stecr_sync: two flip-flop level synchroniser.
// assumes din is quasi-static relative to clk (a toggle or a level).
`timescale 1ns/100ps
`default_nettype none
module stecr_sync (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic din,
    output logic dout
);
    logic meta;

    // meta feeds dout only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule : stecr_sync
`default_nettype wire

//--- verification/sensor_timing_event_config_regs_tb.sv
// sensor_timing_event_config_regs_tb: self-checking bench for the configuration registers.
// assumes shortened units of 8 cycles and a 256-cycle pulse period.
`timescale 1ns/100ps
`default_nettype none
module sensor_timing_event_config_regs_tb;
    logic ref_clk, arst_n, linkClk, linkStart, linkStop, linkWrEn, linkRdEn, linkBusy;
    logic modeActivity, reseedAllCmd, ulpReportTick, autoSwitchReq, pulseOutputPin;
    logic inductiveTxEnable, commWindowOpen;
    logic [7:0] linkAddr, linkWrData, linkRdData, eventRaw, eventOut, q, v;
    logic [2:0] haltReseed, otherReseed, reseedChannel;
    logic [7:0] rstTab [10] = '{8'h03, 8'h00, 8'h00, 8'h08, 8'h14, 8'h00, 8'h00, 8'h20, 8'h01, 8'h07};
    int fails, testsRun, cyc, n;
    stecr_regs #(.ULP_UNIT_CYCLES(8), .AUTO_UNIT_CYCLES(8), .RDY_UNIT_CYCLES(8), .PWM_PERIOD_CYCLES(256))
    stecr_regs_inst (.ref_clk, .arst_n, .linkClk, .linkStart, .linkStop, .linkWrEn, .linkRdEn, .linkAddr,
        .linkWrData, .linkRdData, .linkBusy, .eventRaw, .eventOut, .modeActivity, .ulpReportTick,
        .autoSwitchReq, .haltReseed, .otherReseed, .reseedAllCmd, .reseedChannel, .pulseOutputPin,
        .inductiveTxEnable, .commWindowOpen);
    stecr_host_model stecr_host_model_inst (.linkClk, .linkStart, .linkStop, .linkWrEn, .linkRdEn,
        .linkAddr, .linkWrData, .linkRdData, .linkBusy);
    initial ref_clk = 1'b0;
    always #25 ref_clk = ~ref_clk;
    // hang guard: whole run needs well under this
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        if (fails == 0 && testsRun > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    // readback of a written byte: unmapped reads 0, mixed registers keep writable bits
    function automatic logic [7:0] keep(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'hd3 || a == 8'hd4) return 8'h00;
        if (a == 8'hda) return (d & 8'h81) | 8'h01;
        if (a == 8'hdb) return d & 8'h07;
        return d;
    endfunction : keep
    // cycles until the selected output shows (tick, switch request, window closed)
    task automatic span(input int sel, output int c);
        logic s;
        c = 0;
        s = 1'b0;
        while (s !== 1'b1 && c < 3000) begin
            @(negedge ref_clk);
            c++;
            s = (sel == 0) ? ulpReportTick : (sel == 1) ? autoSwitchReq : ~commWindowOpen;
        end
    endtask : span
    // high cycles of the pulse pin over one period, after one period to settle
    task automatic pwmHigh(output int c);
        c = 0;
        repeat (256) @(negedge ref_clk);
        repeat (256) begin
            @(negedge ref_clk);
            c += int'(pulseOutputPin === 1'b1);
        end
    endtask : pwmHigh
    initial begin
        {arst_n, modeActivity, reseedAllCmd, eventRaw, haltReseed, otherReseed} = '0;
        n = $urandom(56550);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk) arst_n = 1'b1;
        // a write outside the map must leave every reset value alone
        stecr_host_model_inst.acc(1'b1, 8'($urandom) & 8'h3f, 8'($urandom), q);
        for (int i = 0; i < 10; i++) begin
            stecr_host_model_inst.acc(1'b0, 8'hd2 + 8'(i), 8'($urandom), q);
            chk(16'(q), 16'(rstTab[i]));
        end
        for (int i = 1; i < 10; i++) begin
            v = 8'($urandom);
            stecr_host_model_inst.acc(1'b1, 8'hd2 + 8'(i), v, q);
            stecr_host_model_inst.acc(1'b0, 8'hd2 + 8'(i), 8'($urandom), q);
            chk(16'(q), 16'(keep(8'hd2 + 8'(i), v)));
        end
        // masks: all set, all clear, then random
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            stecr_host_model_inst.acc(1'b1, 8'hd7, v, q);
            @(negedge ref_clk) eventRaw = 8'($urandom);
            modeActivity = 1'($urandom);
            @(negedge ref_clk);
            chk(16'(eventOut), 16'(eventRaw & ~v));
            eventRaw = 8'h00;
            modeActivity = 1'b0;
        end
        // last pass: gate all off with reseed-all pending
        for (int i = 0; i < 8; i++) begin
            v = (i == 7) ? 8'h00 : 8'($urandom);
            stecr_host_model_inst.acc(1'b1, 8'hdb, v, q);
            @(negedge ref_clk);
            haltReseed = 3'($urandom);
            otherReseed = i[0] ? 3'($urandom) : 3'h0;
            reseedAllCmd = (i == 7) || ($urandom_range(3) == 0);
            @(negedge ref_clk);
            chk(16'(reseedChannel), 16'((haltReseed & v[2:0]) | otherReseed | {3{reseedAllCmd}}));
            {haltReseed, otherReseed, reseedAllCmd} = '0;
        end
        stecr_host_model_inst.acc(1'b1, 8'hd5, 8'h03, q);
        span(0, n);
        span(0, n);
        chk(16'(n), 16'd24);
        stecr_host_model_inst.acc(1'b1, 8'hd6, 8'h02, q);
        @(negedge ref_clk) modeActivity = 1'b1;
        @(negedge ref_clk) modeActivity = 1'b0;
        span(1, n);
        chk(16'(n >= 15 && n <= 18), 16'h1);
        stecr_host_model_inst.acc(1'b1, 8'hd2, 8'h83, q);
        for (int i = 0; i < 3; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
            stecr_host_model_inst.acc(1'b1, 8'hd8, v, q);
            pwmHigh(n);
            chk(16'(n), 16'(v) + 16'h1);
            chk(16'(inductiveTxEnable), 16'h0);
        end
        stecr_host_model_inst.acc(1'b1, 8'hd2, 8'h03, q);
        pwmHigh(n);
        chk(16'(n), 16'h0);
        chk(16'(inductiveTxEnable), 16'h1);
        // stop closes the window while stop-ignore is clear
        stecr_host_model_inst.acc(1'b1, 8'hda, 8'h01, q);
        stecr_host_model_inst.frame(1'b1);
        repeat (4) @(negedge ref_clk);
        chk(16'(commWindowOpen), 16'h1);
        stecr_host_model_inst.frame(1'b0);
        repeat (4) @(negedge ref_clk);
        chk(16'(commWindowOpen), 16'h0);
        // stop-ignore: window lingers for 2 units, then a start keeps it open
        stecr_host_model_inst.acc(1'b1, 8'hda, 8'h81, q);
        stecr_host_model_inst.acc(1'b1, 8'hd9, 8'h02, q);
        stecr_host_model_inst.frame(1'b1);
        stecr_host_model_inst.frame(1'b0);
        repeat (4) @(negedge ref_clk);
        chk(16'(commWindowOpen), 16'h1);
        span(2, n);
        chk(16'(n >= 5 && n <= 14), 16'h1);
        stecr_host_model_inst.frame(1'b1);
        stecr_host_model_inst.frame(1'b0);
        repeat (6) @(negedge ref_clk);
        stecr_host_model_inst.frame(1'b1);
        repeat (30) @(negedge ref_clk);
        chk(16'(commWindowOpen), 16'h1);
        end_sim();
    end
endmodule : sensor_timing_event_config_regs_tb
`default_nettype wire

//--- verification/stecr_host_model.sv
// stecr_host_model: link-side host that frames starts, stops and register accesses.
// assumes the register block answers on linkClk with linkBusy; the clock runs only through reset, in register accesses and in frames.
`timescale 1ns/100ps
`default_nettype none
module stecr_host_model (
    output logic linkClk,
    output logic linkStart,
    output logic linkStop,
    output logic linkWrEn,
    output logic linkRdEn,
    output logic [7:0] linkAddr,
    output logic [7:0] linkWrData,
    input wire logic [7:0] linkRdData,
    input wire logic linkBusy
);
    logic run;
    // 64 ns link clock, parked low between frames so nothing leans on a free-running clock
    always #32 if (run || linkClk) linkClk = ~linkClk;
    // idle levels; the clock runs through reset so the block sees its edges
    initial begin
        run = 1'b1;
        linkClk = 1'b0;
        linkStart = 1'b0;
        linkStop = 1'b0;
        linkWrEn = 1'b0;
        linkRdEn = 1'b0;
        linkAddr = 8'h00;
        linkWrData = 8'h00;
    end
    // one register access; request held across the taking edge, then released
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        run = 1'b1;
        @(negedge linkClk);
        linkWrEn = wr;
        linkRdEn = ~wr;
        linkAddr = a;
        // settings byte: bit 0 kept set, reserved bits kept clear
        linkWrData = (a == stecr_pkg::ADDR_SERIAL_BUS) ? ((d & stecr_pkg::SERIAL_BUS_WMASK) | 8'h01) : d;
        @(negedge linkClk);
        linkWrEn = 1'b0;
        linkRdEn = 1'b0;
        // released lines show the inverse, never a stale copy
        linkAddr = ~linkAddr;
        linkWrData = ~linkWrData;
        // a hang here runs into the bench's cycle ceiling, which counts it
        while (linkBusy !== 1'b0) @(negedge linkClk);
        q = linkRdData;
        run = 1'b0;
    endtask : acc
    // start or stop pulse, with spacing so the core sees them apart
    task automatic frame(input logic st);
        run = 1'b1;
        @(negedge linkClk);
        linkStart = st;
        linkStop = ~st;
        @(negedge linkClk);
        linkStart = 1'b0;
        linkStop = 1'b0;
        repeat (3) @(negedge linkClk);
        run = 1'b0;
    endtask : frame
endmodule : stecr_host_model
`default_nettype wire
